/* rtl/sup_cfg.svh */
// constants for the supervisor reset and chip-select gating block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`ifndef SUP_CFG_SVH
`define SUP_CFG_SVH

`define SUP_CLK_HZ          100000000
`define SUP_RST_PULSE_MS    200
`define SUP_RST_PULSE_CYC   ((`SUP_CLK_HZ / 1000) * `SUP_RST_PULSE_MS)
`define SUP_SEL_HOLD_US     10
`define SUP_SEL_HOLD_CYC    ((`SUP_CLK_HZ / 1000000) * `SUP_SEL_HOLD_US)
`define SUP_DEB_MS          10
`define SUP_DEB_CYC         ((`SUP_CLK_HZ / 1000) * `SUP_DEB_MS)
`define SUP_WD_SHORT_MS     200
`define SUP_WD_SHORT_CYC    ((`SUP_CLK_HZ / 1000) * `SUP_WD_SHORT_MS)
`define SUP_WD_LONG_MS      1600
`define SUP_WD_LONG_CYC     ((`SUP_CLK_HZ / 1000) * `SUP_WD_LONG_MS)
`define SUP_CNT_W           32

`endif

/* rtl/sup_pkg.sv */
// types for the supervisor reset and chip-select gating block
`include "sup_cfg.svh"
package sup_pkg;
    typedef logic [`SUP_CNT_W-1:0] sup_cnt_t;

    typedef enum logic [1:0] {SEL_PASS, SEL_HOLD, SEL_BLOCK} sup_sel_e;

    typedef struct packed {
        logic [1:0] supply_sync;
        logic [1:0] mr_sync;
        logic [1:0] kick_sync;
        logic [1:0] cs_sync;
        logic       kick_last;
        logic       mr_clean;
        sup_cnt_t   deb_cnt;
        sup_cnt_t   wd_cnt;
        sup_cnt_t   pulse_cnt;
        sup_cnt_t   hold_cnt;
        logic       reset_on;
        sup_sel_e   sel_state;
        logic       cs_out_n;
    } sup_state_s;
endpackage

/* rtl/sup_supervisor.sv */
// reset supervisor with watchdog and external memory select gating
`timescale 1ns/1ps
`default_nettype none
`include "sup_cfg.svh"
module sup_supervisor
    import sup_pkg::*;
#(
    parameter sup_cnt_t PULSE_CYC = `SUP_RST_PULSE_CYC,
    parameter sup_cnt_t HOLD_CYC  = `SUP_SEL_HOLD_CYC,
    parameter sup_cnt_t DEB_CYC   = `SUP_DEB_CYC,
    parameter sup_cnt_t WD_SHORT  = `SUP_WD_SHORT_CYC,
    parameter sup_cnt_t WD_LONG   = `SUP_WD_LONG_CYC
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic supply_ok,
    input  wire logic manual_reset_n,
    input  wire logic watchdog_kick_in,
    input  wire logic watchdog_enable,
    input  wire logic watchdog_long,
    input  wire logic chip_select_in_n,
    output logic      reset_out_n,
    output logic      reset_drive_oe,
    output logic      chip_select_out_n
);
    sup_state_s state_r;
    sup_state_s state_nxt;
    logic       kick_edge;
    logic       wd_expired;
    logic       hold_src;
    sup_cnt_t   wd_limit;

    // --------------------------------------------------------
    // next state
    // --------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        // two-flop synchronisers on the supply, manual reset, kick and select inputs; kick keeps a third stage for edges
        state_nxt.supply_sync = {state_r.supply_sync[0], supply_ok};
        // unconnected pin resolves high at the pad (pullup)
        state_nxt.mr_sync     = {state_r.mr_sync[0], manual_reset_n};
        state_nxt.kick_sync   = {state_r.kick_sync[0], watchdog_kick_in};
        state_nxt.cs_sync     = {state_r.cs_sync[0], chip_select_in_n};
        state_nxt.kick_last   = state_r.kick_sync[1];

        // debounce: level must stand for DEB_CYC before it is taken
        if (state_r.mr_sync[1] == state_r.mr_clean) begin
            state_nxt.deb_cnt = '0;
        end else if (state_r.deb_cnt >= DEB_CYC - 1) begin
            state_nxt.mr_clean = state_r.mr_sync[1];
            state_nxt.deb_cnt  = '0;
        end else begin
            state_nxt.deb_cnt = state_r.deb_cnt + 1'b1;
        end

        // watchdog counter cleared by edges, reset or disable
        // counter parks at the limit so expiry stays seen until reset clears it
        if (state_r.reset_on || kick_edge || !watchdog_enable) begin
            state_nxt.wd_cnt = '0;
        end else if (!wd_expired) begin
            state_nxt.wd_cnt = state_r.wd_cnt + 1'b1;
        end

        // reset pulse: held while a source stands, then one period
        if (hold_src || wd_expired) begin
            state_nxt.reset_on  = 1'b1;
            state_nxt.pulse_cnt = '0;
        end else if (state_r.reset_on) begin
            if (state_r.pulse_cnt >= PULSE_CYC - 1) begin
                state_nxt.reset_on  = 1'b0;
                state_nxt.pulse_cnt = '0;
            end else begin
                state_nxt.pulse_cnt = state_r.pulse_cnt + 1'b1;
            end
        end

        // select gating
        case (state_r.sel_state)
            SEL_PASS: begin
                if (state_nxt.reset_on && !state_r.cs_sync[1]) begin
                    state_nxt.sel_state = SEL_HOLD;
                    state_nxt.hold_cnt  = '0;
                end else if (state_nxt.reset_on) begin
                    state_nxt.sel_state = SEL_BLOCK;
                end
            end
            SEL_HOLD: begin
                state_nxt.hold_cnt = state_r.hold_cnt + 1'b1;
                if (state_r.cs_sync[1] || state_r.hold_cnt >= HOLD_CYC - 1) begin
                    state_nxt.sel_state = SEL_BLOCK;
                end
            end
            SEL_BLOCK: begin
                if (!state_nxt.reset_on) begin
                    state_nxt.sel_state = SEL_PASS;
                end
            end
            default: state_nxt.sel_state = SEL_BLOCK;
        endcase
        // output low only while passing or holding with input low
        state_nxt.cs_out_n = !(((state_nxt.sel_state == SEL_PASS) && !state_nxt.reset_on)
                               || (state_nxt.sel_state == SEL_HOLD))
                             || state_r.cs_sync[1];
    end

    // --------------------------------------------------------
    // helper terms
    // --------------------------------------------------------
    assign kick_edge  = state_r.kick_sync[1] ^ state_r.kick_last;
    assign wd_limit   = watchdog_long ? WD_LONG : WD_SHORT;
    assign wd_expired = watchdog_enable && (state_r.wd_cnt >= wd_limit);
    assign hold_src   = !state_r.supply_sync[1] || !state_r.mr_clean;

    // state register with clock enable
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r           <= '0;
            // select and manual reset stages idle high so no false request follows reset
            state_r.mr_sync   <= 2'h3;
            state_r.cs_sync   <= 2'h3;
            state_r.mr_clean  <= 1'b1;
            state_r.reset_on  <= 1'b1;
            state_r.sel_state <= SEL_BLOCK;
            state_r.cs_out_n  <= 1'b1;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // open-drain reset: enable high while pulling low
    // data value tied low; the pad floats high through its pull-up when released
    assign reset_out_n       = 1'b0;
    assign reset_drive_oe    = state_r.reset_on;
    assign chip_select_out_n = state_r.cs_out_n;

    // --------------------------------------------------------
    // checks
    // --------------------------------------------------------
    sequence s_src_gone;
        !hold_src && !wd_expired && $past(hold_src);
    endsequence

    // reset output checks
    a_reset_holds_src: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && hold_src |=> state_r.reset_on)
        else $error("reset released while source active");
    a_reset_stretch: assert property (@(posedge clock) disable iff (!rst_n)
        (clk_en && state_r.reset_on && !hold_src && !wd_expired && state_r.pulse_cnt == '0)
        |=> state_r.reset_on)
        else $error("reset released before pulse period");
    a_reset_release: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(state_r.reset_on) |-> $past(state_r.pulse_cnt) >= PULSE_CYC - 1)
        else $error("reset released early");

    // select gating checks
    a_sel_gated: assert property (@(posedge clock) disable iff (!rst_n)
        !chip_select_out_n |-> !$past(state_r.cs_sync[1]))
        else $error("select low while input high");
    a_sel_blocked: assert property (@(posedge clock) disable iff (!rst_n)
        state_r.sel_state == SEL_BLOCK |-> chip_select_out_n)
        else $error("select low while blocked");
    a_hold_bound: assert property (@(posedge clock) disable iff (!rst_n)
        state_r.sel_state == SEL_HOLD |-> state_r.hold_cnt < HOLD_CYC)
        else $error("select hold overran");

    // watchdog and debounce checks
    a_wd_fires: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && wd_expired |=> state_r.reset_on)
        else $error("watchdog expiry did not reset");
    a_wd_cleared: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && kick_edge |=> state_r.wd_cnt == '0)
        else $error("kick edge did not clear watchdog");
    a_wd_disable: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !watchdog_enable |=> state_r.wd_cnt == '0 && !wd_expired)
        else $error("disabled watchdog counted");
    a_mr_debounce: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(state_r.mr_clean) |-> $past(state_r.mr_sync[1]) == state_r.mr_clean)
        else $error("debounced level wrong");

    // select hold entry and exit, built from the capture steps
    sequence s_sel_caught;
        state_r.sel_state == SEL_PASS && !state_r.reset_on && !state_r.cs_sync[1];
    endsequence
    sequence s_src_fires;
        hold_src || wd_expired;
    endsequence
    a_sel_hold_entry: assert property (@(posedge clock) disable iff (!rst_n)
        s_sel_caught ##0 s_src_fires ##0 clk_en
        |=> state_r.sel_state == SEL_HOLD && !chip_select_out_n)
        else $error("select not held at reset entry");
    a_sel_hold_exit: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state_r.sel_state == SEL_HOLD && state_r.cs_sync[1]
        |=> chip_select_out_n && state_r.sel_state == SEL_BLOCK)
        else $error("select hold kept after input rose");
    a_sel_reset_high: assert property (@(posedge clock) disable iff (!rst_n)
        state_r.reset_on && state_r.sel_state != SEL_HOLD |-> chip_select_out_n)
        else $error("select low during reset outside hold");

    // pulse restart when the source leaves, and counter range
    a_src_release: assert property (@(posedge clock) disable iff (!rst_n)
        s_src_gone |-> state_r.reset_on && state_r.pulse_cnt == '0)
        else $error("pulse count not restarted when source left");
    a_pulse_bound: assert property (@(posedge clock) disable iff (!rst_n)
        state_r.pulse_cnt < PULSE_CYC)
        else $error("pulse counter overran");

    // watchdog counting and clearing
    a_wd_reset_clear: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state_r.reset_on |=> state_r.wd_cnt == '0)
        else $error("watchdog ran during reset");
    a_wd_count: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && watchdog_enable && !state_r.reset_on && !kick_edge && !wd_expired
        |=> state_r.wd_cnt == $past(state_r.wd_cnt) + 1'b1)
        else $error("watchdog did not count");

    // debounce timing
    a_mr_stable: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(state_r.mr_clean) |-> $past(state_r.deb_cnt) >= DEB_CYC - 1)
        else $error("manual reset taken before debounce");
    a_deb_bound: assert property (@(posedge clock) disable iff (!rst_n)
        state_r.deb_cnt < DEB_CYC)
        else $error("debounce counter overran");
endmodule
`default_nettype wire

/* sim/sup_host_model.sv */
// host model: kicks the watchdog and requests the memory select
`timescale 1ns/1ps
`default_nettype none
module sup_host_model (
    input  wire logic clock,
    input  wire logic kick_on,
    input  wire logic sel_req,
    output logic      watchdog_kick_in,
    output logic      chip_select_in_n
);
    logic [2:0] kick_cnt_r = 3'h0;
    logic       kick_r     = 1'b0;
    // --------------------------------
    // kick edge every 8 cycles, select follows request at once
    // --------------------------------
    always @(negedge clock) begin
        kick_cnt_r <= kick_cnt_r + 3'h1;
        if (kick_on && kick_cnt_r == 3'h0) begin
            kick_r <= ~kick_r;
        end
    end
    // select driven straight from the request, no race with the bench
    assign watchdog_kick_in = kick_r;
    assign chip_select_in_n = ~sel_req;
endmodule
`default_nettype wire

/* sim/tb_sup_supervisor.sv */
// testbench for the supervisor block
`timescale 1ns/1ps
`default_nettype none
module tb_sup_supervisor;
    import sup_pkg::*;
    localparam int P = 20, H = 20, D = 4, WS = 50, WL = 400;
    logic clock, rst_n = 0, supply_ok = 1, mr_n = 1, wd_en = 0, wd_long = 0;
    logic kick_on = 0, sel_req = 0, clk_en = 1;
    wire logic kick, cs_in_n, rst_out_n, oe, cs_out_n;
    int mismatches = 0, n_compared = 0, n;
    sup_host_model host (.clock(clock), .kick_on(kick_on), .sel_req(sel_req),
        .watchdog_kick_in(kick), .chip_select_in_n(cs_in_n));
    sup_supervisor #(.PULSE_CYC(sup_cnt_t'(P)), .HOLD_CYC(sup_cnt_t'(H)),
        .DEB_CYC(sup_cnt_t'(D)), .WD_SHORT(sup_cnt_t'(WS)), .WD_LONG(sup_cnt_t'(WL)))
    dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .supply_ok(supply_ok),
        .manual_reset_n(mr_n), .watchdog_kick_in(kick), .watchdog_enable(wd_en),
        .watchdog_long(wd_long), .chip_select_in_n(cs_in_n), .reset_out_n(rst_out_n),
        .reset_drive_oe(oe), .chip_select_out_n(cs_out_n));
    // clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %b, expected %b", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask
    // bounded wait for reset output level, counting cycles
    task automatic wait_oe(input logic lvl, input int lim);
        n = 0;
        while (oe !== lvl && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic t_power_up;
        wait_oe(1'b0, P + 20);
        check(n >= P && n <= P + 6, 1'b1);
        check(rst_out_n, 1'b0);
        sel_req = 1;
        cyc(4);
        check(cs_out_n, 1'b0);
        sel_req = 0;
        cyc(4);
        check(cs_out_n, 1'b1);
    endtask
    // supply drop with select low: hold runs out, or input rises first
    task automatic t_supply(input logic early);
        sel_req = 1;
        cyc(4);
        supply_ok = 0;
        wait_oe(1'b1, 6);
        check(oe, 1'b1);
        check(cs_out_n, 1'b0);
        if (early) sel_req = 0;
        cyc(early ? 5 : H - 4);
        check(cs_out_n, early);
        cyc(6);
        check(cs_out_n, 1'b1);
        cyc(100);
        check(oe, 1'b1);
        check(cs_out_n, 1'b1);
        sel_req = 0;
        supply_ok = 1;
        wait_oe(1'b0, P + 10);
        check(n >= P && oe === 1'b0, 1'b1);
    endtask
    task automatic t_manual;
        mr_n = 0;
        cyc(2);
        mr_n = 1;
        cyc(10);
        check(oe, 1'b0);
        mr_n = 0;
        wait_oe(1'b1, D + 8);
        cyc(50);
        check(oe, 1'b1);
        mr_n = 1;
        wait_oe(1'b0, P + D + 10);
        check(n >= P + D && oe === 1'b0, 1'b1);
    endtask
    task automatic t_watchdog;
        kick_on = 1;
        wd_en = 1;
        cyc(WL + 50);
        check(oe, 1'b0);
        kick_on = 0;
        wait_oe(1'b1, WS + 10);
        check(oe === 1'b1 && n >= WS - 12, 1'b1);
        wait_oe(1'b0, P + 10);
        check(oe, 1'b0);
        wd_long = 1;
        wait_oe(1'b1, WL + 20);
        check(oe === 1'b1 && n >= WL - 20, 1'b1);
        wait_oe(1'b0, P + 10);
        wd_en = 0;
        cyc(WL + 50);
        check(oe, 1'b0);
    endtask
    // frozen enable stops every count; the pulse resumes once it returns
    task automatic t_freeze;
        supply_ok = 0;
        wait_oe(1'b1, 6);
        check(oe, 1'b1);
        clk_en = 0;
        supply_ok = 1;
        cyc(P + 20);
        check(oe, 1'b1);
        clk_en = 1;
        wait_oe(1'b0, P + 10);
        check(n >= P && oe === 1'b0, 1'b1);
    endtask
    // main sequence
    initial begin
        cyc(12);
        rst_n = 1;
        t_power_up();
        t_supply(1'b0);
        t_supply(1'b1);
        t_manual();
        t_freeze();
        t_watchdog();
        wrap_up();
    end
    // hang guard
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
